// file: hdl/dpmc_defines.svh
// offsets, field positions, widths and counts for the mode correction block
// assumes word-indexed register port, 32-bit data
`ifndef DPMC_DEFINES_SVH
`define DPMC_DEFINES_SVH
`define DPMC_ADDR_W         4
`define DPMC_OFF_CTRL_A     4'h0
`define DPMC_OFF_CTRL_B     4'h1
`define DPMC_OFF_STATUS     4'h2
`define DPMC_OFF_TCOUNT     4'h3
`define DPMC_OFF_SCOUNT     4'h4
`define DPMC_OFF_IRQ_STAT   4'h5
`define DPMC_OFF_IRQ_MASK   4'h6
`define DPMC_OFF_TPOS_CORR  4'h7
`define DPMC_OFF_SPOS_CORR  4'h8
`define DPMC_OFF_TPOS_BASE  4'h9
`define DPMC_OFF_SPOS_BASE  4'ha
`define DPMC_OFF_T_TARGET   4'hb
`define DPMC_OFF_S_TARGET   4'hc
`define DPMC_BIT_EMERG      0
`define DPMC_BIT_ENABLE     0
`define DPMC_BIT_LOCK       0
`define DPMC_BIT_DIR        1
`define DPMC_BIT_SWEN       31
`define DPMC_SYN_LSB        0
`define DPMC_OLD_LSB        8
`define DPMC_SYN_W          8
`define DPMC_IRQ_MISS       0
`define DPMC_IRQ_DIR        1
`define DPMC_IRQ_W          2
`define DPMC_GAPS_RELOCK    4
`endif

// file: hdl/dpmc_pkg.sv
// types shared by the mode correction block
// assumes nothing beyond the defines header
package dpmc_pkg;
	typedef enum logic [1:0] {
		DPMC_PEND_NONE,
		DPMC_PEND_STATE,
		DPMC_PEND_TRIG
	} dpmc_pend_type;
endpackage : dpmc_pkg

// file: hdl/dpmc_pos_corr.sv
// one position correction register with its event-driven recompute
// assumes event and write strobes on the module clock
`include "dpmc_defines.svh"
module dpmc_pos_corr #(
	parameter int W = 24
) (
	// clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_resetn,
	// operands
	input  wire logic [W-1:0] i_base,
	input  wire logic [W-1:0] i_incr,
	input  wire logic [W-1:0] i_target,
	input  wire logic         i_backward,
	// controls
	input  wire logic         i_calc,
	input  wire logic         i_load_base,
	input  wire logic         i_wr,
	input  wire logic [W-1:0] i_wdata,
	// result
	output logic      [W-1:0] o_value
);
	logic [W-1:0] value_ff;
	logic [W-1:0] nxt_value;
	wire  [W-1:0] delta = i_incr - i_target;
	wire  [W-1:0] calc  = i_backward ? i_base - delta : i_base + delta;
	// software write has lowest priority against hardware updates
	assign nxt_value = i_calc ? calc :
		i_load_base ? i_base :
		i_wr ? i_wdata : value_ff;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			value_ff <= '0;
		end else begin
			value_ff <= nxt_value;
		end
	end
	assign o_value = value_ff;
endmodule : dpmc_pos_corr

// file: hdl/dpmc_sync_count.sv
// one synchronisation-count register with its old-value field
// assumes the write strobe is already decoded for this register
`include "dpmc_defines.svh"
module dpmc_sync_count (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	// write port
	input  wire logic        i_wr,
	input  wire logic [31:0] i_wdata,
	// contents
	output logic      [31:0] o_value
);
	localparam int SW = `DPMC_SYN_W;
	logic [SW-1:0] syn_ff;
	logic [SW-1:0] old_ff;
	logic          swen_ff;
	wire           swen_new = i_wdata[`DPMC_BIT_SWEN];
	wire  [SW-1:0] syn_w    = i_wdata[`DPMC_SYN_LSB +: SW];
	wire  [SW-1:0] old_w    = i_wdata[`DPMC_OLD_LSB +: SW];
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			syn_ff  <= '0;
			old_ff  <= '0;
			swen_ff <= 1'b0;
		end else if (i_wr) begin
			swen_ff <= swen_new;
			// [RL7] old from write data
			if (swen_new) begin
				syn_ff <= syn_w;
				old_ff <= old_w;
			end
		end
	end
	always_comb begin
		o_value = '0;
		o_value[`DPMC_SYN_LSB +: SW] = syn_ff;
		o_value[`DPMC_OLD_LSB +: SW] = old_ff;
		o_value[`DPMC_BIT_SWEN] = swen_ff;
	end
endmodule : dpmc_sync_count

// file: hdl/dpmc_top.sv
// mode correction, lock and count logic of the digital loop
// assumes event pulses come from capture logic on i_clk_sys
// Notes on behaviour
// [RL1] normal to emergency: state correction recomputed at next state slope
// [RL2] emergency to normal: trigger correction recomputed at next trigger slope
// [RL3] with no further events software writes the corrections itself
// [RL4] enable low stops loop; restart in new mode loads correction from base
// [RL5] in emergency mode a direction change clears the lock flag
// [RL6] lock flag set again after a fixed count of consecutive gaps
// [RL7] count write with sync enable loads old field from written data
// [RL8] software wanting true old value reads count then writes it back
// [RL9] each state gap raises a missing-state flag and interrupt
// [RL10] gap counter restarts on direction change or non-gap state event
//
// Chosen here: the register addresses and the plain strobed port.
`include "dpmc_defines.svh"
module dpmc_top
	import dpmc_pkg::*;
#(
	parameter int PW        = 24,
	parameter int GAP_COUNT = `DPMC_GAPS_RELOCK
) (
	// clock and reset
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_resetn,
	// register port
	input  wire logic [`DPMC_ADDR_W-1:0] i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic      [31:0]             o_rdata,
	// capture events, same clock
	input  wire logic                    i_trig_evt,
	input  wire logic                    i_state_evt,
	input  wire logic                    i_state_gap,
	input  wire logic                    i_dir_change,
	input  wire logic                    i_backward,
	input  wire logic [PW-1:0]           i_incr_count,
	// status
	output logic                         o_loop_active,
	output logic                         o_first_lock,
	output logic                         o_irq
);
	localparam int IW = `DPMC_IRQ_W;
	localparam int GW = $clog2(GAP_COUNT + 1);
	localparam logic [GW-1:0] GAP_LIM = GW'(GAP_COUNT);

	// register port decode
	wire wr_ctrl_a = i_wr && (i_addr == `DPMC_OFF_CTRL_A);
	wire wr_ctrl_b = i_wr && (i_addr == `DPMC_OFF_CTRL_B);
	wire wr_tcount = i_wr && (i_addr == `DPMC_OFF_TCOUNT);
	wire wr_scount = i_wr && (i_addr == `DPMC_OFF_SCOUNT);
	wire wr_istat  = i_wr && (i_addr == `DPMC_OFF_IRQ_STAT);
	wire wr_imask  = i_wr && (i_addr == `DPMC_OFF_IRQ_MASK);
	wire wr_tcorr  = i_wr && (i_addr == `DPMC_OFF_TPOS_CORR);
	wire wr_scorr  = i_wr && (i_addr == `DPMC_OFF_SPOS_CORR);
	wire wr_tbase  = i_wr && (i_addr == `DPMC_OFF_TPOS_BASE);
	wire wr_sbase  = i_wr && (i_addr == `DPMC_OFF_SPOS_BASE);
	wire wr_ttar   = i_wr && (i_addr == `DPMC_OFF_T_TARGET);
	wire wr_star   = i_wr && (i_addr == `DPMC_OFF_S_TARGET);

	// control state
	logic               emerg_shadow_ff;
	logic               emerg_active_ff;
	logic               enable_ff;
	logic               lock_ff;
	logic [GW-1:0]      gaps_ff;
	logic [IW-1:0]      istat_ff;
	logic [IW-1:0]      imask_ff;
	logic [PW-1:0]      tbase_ff;
	logic [PW-1:0]      sbase_ff;
	logic [PW-1:0]      ttar_ff;
	logic [PW-1:0]      star_ff;
	logic [31:0]        rdata_ff;
	dpmc_pend_type      pend_ff;
	dpmc_pend_type      nxt_pend;
	logic [GW-1:0]      nxt_gaps;
	logic               nxt_lock;
	logic [IW-1:0]      nxt_istat;
	logic [PW-1:0]      tcorr;
	logic [PW-1:0]      scorr;
	logic [31:0]        tcount;
	logic [31:0]        scount;

	wire new_emerg  = i_wdata[`DPMC_BIT_EMERG];
	wire new_enable = i_wdata[`DPMC_BIT_ENABLE];
	wire mode_flip  = wr_ctrl_a && (new_emerg != emerg_shadow_ff);
	// a mode flip while stopped is taken over at restart
	wire restart    = wr_ctrl_b && new_enable && !enable_ff;
	wire restart_flip = restart && (emerg_shadow_ff != emerg_active_ff);
	wire nxt_active = wr_ctrl_a ? new_emerg : emerg_shadow_ff;
	wire trig_in    = enable_ff && i_trig_evt;
	wire state_in   = enable_ff && i_state_evt;
	wire gap_in     = enable_ff && i_state_gap;
	wire dir_in     = enable_ff && i_dir_change;

	// [RL1] state slope recompute
	wire scalc = state_in && (pend_ff == DPMC_PEND_STATE);
	// [RL2] trigger slope recompute
	wire tcalc = trig_in && (pend_ff == DPMC_PEND_TRIG);
	// [RL4] restart loads base
	wire sload = restart_flip && emerg_shadow_ff;
	wire tload = restart_flip && !emerg_shadow_ff;

	// pending correction after a mode change while running
	always_comb begin
		nxt_pend = pend_ff;
		case (pend_ff)
			DPMC_PEND_NONE: nxt_pend = DPMC_PEND_NONE;
			DPMC_PEND_STATE: begin
				if (scalc) begin
					nxt_pend = DPMC_PEND_NONE;
				end
			end
			DPMC_PEND_TRIG: begin
				if (tcalc) begin
					nxt_pend = DPMC_PEND_NONE;
				end
			end
			default: nxt_pend = DPMC_PEND_NONE;
		endcase
		if (mode_flip && enable_ff) begin
			nxt_pend = new_emerg ? DPMC_PEND_STATE : DPMC_PEND_TRIG;
		end
		// [RL4] disable drops pending
		if (!enable_ff || restart) begin
			nxt_pend = DPMC_PEND_NONE;
		end
	end

	// lock flag and gap counter
	always_comb begin
		nxt_gaps = gaps_ff;
		nxt_lock = lock_ff;
		// [RL10] gap counter restart
		if (dir_in || (state_in && !gap_in)) begin
			nxt_gaps = '0;
		end else if (gap_in && !lock_ff && gaps_ff != GAP_LIM) begin
			nxt_gaps = gaps_ff + GW'(1);
		end
		// [RL6] relock after gaps
		if (!lock_ff && gap_in && !dir_in && gaps_ff + GW'(1) >= GAP_LIM) begin
			nxt_lock = 1'b1;
		end
		// [RL5] direction clears lock
		if (dir_in && emerg_active_ff) begin
			nxt_lock = 1'b0;
		end
		if (!enable_ff) begin
			nxt_gaps = '0;
		end
	end

	// [RL9] missing-state flag, set beats clear
	always_comb begin
		nxt_istat = istat_ff;
		if (wr_istat) begin
			nxt_istat = istat_ff & ~i_wdata[IW-1:0];
		end
		nxt_istat[`DPMC_IRQ_MISS] = nxt_istat[`DPMC_IRQ_MISS] | gap_in;
		nxt_istat[`DPMC_IRQ_DIR]  = nxt_istat[`DPMC_IRQ_DIR] | dir_in;
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			emerg_shadow_ff <= 1'b0;
			emerg_active_ff <= 1'b0;
			enable_ff       <= 1'b0;
			pend_ff         <= DPMC_PEND_NONE;
		end else begin
			if (wr_ctrl_a) begin
				emerg_shadow_ff <= new_emerg;
			end
			if (wr_ctrl_b) begin
				enable_ff <= new_enable;
			end
			// active mode frozen while stopped, so restart can see the flip
			if (enable_ff || restart) begin
				emerg_active_ff <= nxt_active;
			end
			pend_ff <= nxt_pend;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			lock_ff  <= 1'b1;
			gaps_ff  <= '0;
			istat_ff <= '0;
			imask_ff <= '0;
		end else begin
			lock_ff  <= nxt_lock;
			gaps_ff  <= nxt_gaps;
			istat_ff <= nxt_istat;
			if (wr_imask) begin
				imask_ff <= i_wdata[IW-1:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			tbase_ff <= '0;
			sbase_ff <= '0;
			ttar_ff  <= '0;
			star_ff  <= '0;
		end else begin
			if (wr_tbase) begin
				tbase_ff <= i_wdata[PW-1:0];
			end
			if (wr_sbase) begin
				sbase_ff <= i_wdata[PW-1:0];
			end
			if (wr_ttar) begin
				ttar_ff <= i_wdata[PW-1:0];
			end
			if (wr_star) begin
				star_ff <= i_wdata[PW-1:0];
			end
		end
	end

	// [RL3] software write path kept open
	dpmc_pos_corr #(
		.W (PW)
	) u_state_corr (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_base      (sbase_ff),
		.i_incr      (i_incr_count),
		.i_target    (star_ff),
		.i_backward  (i_backward),
		.i_calc      (scalc),
		.i_load_base (sload),
		.i_wr        (wr_scorr),
		.i_wdata     (i_wdata[PW-1:0]),
		.o_value     (scorr)
	);

	dpmc_pos_corr #(
		.W (PW)
	) u_trig_corr (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_base      (tbase_ff),
		.i_incr      (i_incr_count),
		.i_target    (ttar_ff),
		.i_backward  (i_backward),
		.i_calc      (tcalc),
		.i_load_base (tload),
		.i_wr        (wr_tcorr),
		.i_wdata     (i_wdata[PW-1:0]),
		.o_value     (tcorr)
	);

	dpmc_sync_count u_tcount (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_wr      (wr_tcount),
		.i_wdata   (i_wdata),
		.o_value   (tcount)
	);

	dpmc_sync_count u_scount (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_wr      (wr_scount),
		.i_wdata   (i_wdata),
		.o_value   (scount)
	);

	// read mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (i_addr)
			`DPMC_OFF_CTRL_A:    rd_mux[`DPMC_BIT_EMERG] = emerg_shadow_ff;
			`DPMC_OFF_CTRL_B:    rd_mux[`DPMC_BIT_ENABLE] = enable_ff;
			`DPMC_OFF_STATUS: begin
				rd_mux[`DPMC_BIT_LOCK] = lock_ff;
				rd_mux[`DPMC_BIT_DIR]  = i_backward;
			end
			`DPMC_OFF_TCOUNT:    rd_mux = tcount;
			`DPMC_OFF_SCOUNT:    rd_mux = scount;
			`DPMC_OFF_IRQ_STAT:  rd_mux[IW-1:0] = istat_ff;
			`DPMC_OFF_IRQ_MASK:  rd_mux[IW-1:0] = imask_ff;
			`DPMC_OFF_TPOS_CORR: rd_mux[PW-1:0] = tcorr;
			`DPMC_OFF_SPOS_CORR: rd_mux[PW-1:0] = scorr;
			`DPMC_OFF_TPOS_BASE: rd_mux[PW-1:0] = tbase_ff;
			`DPMC_OFF_SPOS_BASE: rd_mux[PW-1:0] = sbase_ff;
			`DPMC_OFF_T_TARGET:  rd_mux[PW-1:0] = ttar_ff;
			`DPMC_OFF_S_TARGET:  rd_mux[PW-1:0] = star_ff;
			default:             rd_mux = '0;
		endcase
	end

	// read data stands one cycle only
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign o_rdata       = rdata_ff;
	assign o_loop_active = enable_ff;
	assign o_first_lock  = lock_ff;
	assign o_irq         = |(istat_ff & imask_ff);
endmodule : dpmc_top

// file: tb/dpmc_checker.sv
// port assertions for the mode correction top
// assumes one module clock and the hand-over register map
module dpmc_checker #(
	parameter int GAP_COUNT = 4
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [31:0] o_rdata,
	// events and status
	input  wire logic        i_state_evt,
	input  wire logic        i_state_gap,
	input  wire logic        i_dir_change,
	input  wire logic        o_loop_active,
	input  wire logic        o_first_lock,
	input  wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mask_ff;
	logic [7:0] gaps_ff;
	wire        gap_clr = !o_loop_active || i_dir_change ||
	                      (i_state_evt && !i_state_gap);
	// shadow of the mask and of the consecutive gap run
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			mask_ff <= 2'h0;
			gaps_ff <= 8'h0;
		end else begin
			if (i_wr && i_addr == 4'h6)
				mask_ff <= i_wdata[1:0];
			if (gap_clr)
				gaps_ff <= 8'h0;
			else if (i_state_gap)
				gaps_ff <= gaps_ff + 8'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside read");
	a_unmapped_zero: assert property (
		i_rd && i_addr > 4'hc |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_enable_bit: assert property (
		i_wr && i_addr == 4'h1 |=> o_loop_active == 1'($past(i_wdata)))
		else $error("loop enable does not follow write");
	a_lock_clear: assert property (
		$fell(o_first_lock) |-> $past(i_dir_change))
		else $error("lock fell without direction change");
	a_relock_gaps: assert property (
		$rose(o_first_lock) |-> gaps_ff == 8'(GAP_COUNT))
		else $error("lock rose at wrong gap count");
	a_lock_hold: assert property (
		!o_first_lock && !i_state_gap |=> !o_first_lock)
		else $error("lock rose without a gap");
	a_gap_irq: assert property (
		i_state_gap && o_loop_active && mask_ff[0] |=> o_irq)
		else $error("gap did not raise interrupt");
	a_irq_masked: assert property (mask_ff == 2'h0 |-> !o_irq)
		else $error("interrupt high while masked");
	a_sync_write: assert property (
		i_wr && i_addr inside {4'h3, 4'h4} && i_wdata[31] ##1
		i_rd && $stable(i_addr) |=>
		o_rdata[15:0] == 16'($past(i_wdata, 2)))
		else $error("old field not taken from write data");
endmodule : dpmc_checker

// file: tb/dpmc_capture_model.sv
// capture channel model: turns bench requests into event pulses
// assumes requests change just after a rising edge of the module clock
module dpmc_capture_model (
	// clock
	input  wire logic        i_clk_sys,
	// requests, kind bits: dir, gap, state, trigger
	input  wire logic [3:0]  i_kind,
	input  wire logic        i_bwd,
	input  wire logic [23:0] i_incr,
	// events towards the block
	output logic      [3:0]  o_evt,
	output logic             o_backward,
	output logic      [23:0] o_incr_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  evt_ff  = 4'h0;
	logic        bwd_ff  = 1'b0;
	logic [23:0] incr_ff = 24'h0;
	// a channel reports each slope once; a pulse follows its request one cycle later and lasts as long as it
	always @(posedge i_clk_sys) begin
		evt_ff  <= i_kind;
		bwd_ff  <= i_bwd;
		incr_ff <= i_incr;
	end
	assign o_evt        = evt_ff;
	assign o_backward   = bwd_ff;
	assign o_incr_count = incr_ff;
endmodule : dpmc_capture_model

// file: tb/dpmc_top_tb.sv
// self-checking bench for the mode correction top
// assumes the hand-over register map and a 20 MHz module clock
module dpmc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GAPS = 2;
	logic        i_clk_sys   = 1'b0;
	logic        i_resetn    = 1'b0;
	logic [3:0]  i_addr      = 4'h0;
	logic [31:0] i_wdata     = 32'h0;
	logic        i_wr        = 1'b0;
	logic        i_rd        = 1'b0;
	logic [3:0]  kind        = 4'h0;
	logic        bwd         = 1'b0;
	logic [23:0] incr        = 24'h0;
	logic [3:0]  evt;
	logic [23:0] inc_cnt;
	logic [31:0] o_rdata;
	logic        back, act, lock, irq, rd_ff;
	logic [23:0] sbase, tbase, star, ttar, v;
	logic [31:0] exp_q[$];
	int          n_mismatch  = 0;
	int          checks_done = 0;

	always #25 i_clk_sys = ~i_clk_sys;

	dpmc_capture_model cap_u (.i_clk_sys(i_clk_sys), .i_kind(kind),
		.i_bwd(bwd), .i_incr(incr), .o_evt(evt), .o_backward(back),
		.o_incr_count(inc_cnt));
	dpmc_top #(.GAP_COUNT(GAPS)) dut_u (.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_trig_evt(evt[0]), .i_state_evt(evt[1]), .i_state_gap(evt[2]),
		.i_dir_change(evt[3]), .i_backward(back), .i_incr_count(inc_cnt),
		.o_loop_active(act), .o_first_lock(lock), .o_irq(irq));

	task automatic chk_rdata(logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH rdata exp %h got %h", e, g);
		end
	endtask : chk_rdata
	task automatic chk_pin(string nm, logic e, logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask : chk_pin
	task automatic bus(logic w, logic r, logic [3:0] a, logic [31:0] d);
		i_wr    <= w;
		i_rd    <= r;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
	endtask : bus
	task automatic rd(logic [3:0] a, logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h0);
	endtask : rd
	task automatic wr(logic [3:0] a, logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	task automatic ev(logic [3:0] k);
		bus(1'b0, 1'b0, 4'h0, 32'h0);
		kind <= k;
		@(posedge i_clk_sys);
		kind <= 4'h0;
		repeat (2) @(posedge i_clk_sys);
	endtask : ev
	// interrupt is combinational of registers: let the edge settle first
	task automatic flag(logic e);
		#1 chk_pin("irq", e, irq);
	endtask : flag
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	// read data stand only in the cycle after the strobe
	always @(posedge i_clk_sys) rd_ff <= i_rd;
	always @(negedge i_clk_sys) begin
		if (rd_ff === 1'b1)
			chk_rdata(exp_q.pop_front(), o_rdata);
	end

	initial begin
		repeat (3000) @(posedge i_clk_sys);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h458118d0));
		sbase = 24'($urandom);
		tbase = 24'($urandom);
		star  = 24'($urandom);
		ttar  = 24'($urandom);
		v     = 24'($urandom);
		incr  = 24'($urandom);
		repeat (3) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		rd(4'h1, 32'h0);
		rd(4'h2, 32'h1);
		rd(4'hf, 32'h0);
		wr(4'h1, 32'h1);
		#1 chk_pin("loop_active", 1'b1, act);
		wr(4'ha, {8'h0, sbase});
		wr(4'hc, {8'h0, star});
		wr(4'h9, {8'h0, tbase});
		wr(4'hb, {8'h0, ttar});
		wr(4'h8, {8'h0, v});
		wr(4'h7, {8'h0, ~v});
		wr(4'h0, 32'h1);
		ev(4'h1);
		rd(4'h8, {8'h0, v});
		ev(4'h2);
		rd(4'h8, {8'h0, sbase + (inc_cnt - star)});
		bwd <= 1'b1;
		wr(4'h0, 32'h0);
		ev(4'h2);
		rd(4'h7, {8'h0, ~v});
		ev(4'h1);
		rd(4'h7, {8'h0, tbase - (inc_cnt - ttar)});
		bwd <= 1'b0;
		// restart straight into the other mode, ending in emergency
		for (int m = 0; m < 3; m++) begin
			wr(4'h1, 32'h0);
			wr(4'h0, {31'h0, !m[0]});
			wr(4'h1, 32'h1);
			rd(m[0] ? 4'h7 : 4'h8, {8'h0, m[0] ? tbase : sbase});
		end
		wr(4'h6, 32'h3);
		ev(4'h8);
		rd(4'h2, 32'h0);
		chk_pin("first_lock", 1'b0, lock);
		// a plain state slope in mid-run restarts the gap count
		for (int g = 0; g < 2 * GAPS - 1; g++) begin
			ev(g == GAPS - 1 ? 4'h2 : 4'h4);
			rd(4'h2, 32'h0);
		end
		ev(4'h4);
		rd(4'h2, 32'h1);
		chk_pin("first_lock", 1'b1, lock);
		rd(4'h5, 32'h3);
		flag(1'b1);
		wr(4'h5, 32'h3);
		rd(4'h5, 32'h0);
		wr(4'h6, 32'h0);
		ev(4'h4);
		flag(1'b0);
		rd(4'h5, 32'h1);
		wr(4'h6, 32'h1);
		flag(1'b1);
		wr(4'h5, 32'h1);
		flag(1'b0);
		for (int a = 3; a <= 4; a++) begin
			v = 24'($urandom);
			wr(a[3:0], {16'h8000, v[15:0]});
			rd(a[3:0], {16'h8000, v[15:0]});
			wr(a[3:0], {16'h0, ~v[15:0]});
			rd(a[3:0], {16'h0, v[15:0]});
			// software keeps the true old value: read, then write it back
			wr(a[3:0], {16'h8000, v[7:0], ~v[7:0]});
			rd(a[3:0], {16'h8000, v[7:0], ~v[7:0]});
		end
		bus(1'b0, 1'b0, 4'h0, 32'h0);
		repeat (2) @(posedge i_clk_sys);
		print_verdict();
	end
endmodule : dpmc_top_tb

bind dpmc_top dpmc_checker #(.GAP_COUNT(GAP_COUNT)) chk_u (
	.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_state_evt(i_state_evt), .i_state_gap(i_state_gap),
	.i_dir_change(i_dir_change), .o_loop_active(o_loop_active),
	.o_first_lock(o_first_lock), .o_irq(o_irq));
